// [asf_adc_status_flags.sv]
`include "asf_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module asf_adc_status_flags
(
  // clock and power-on reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // host register reads, already decoded from the command byte
  input wire logic host_rd_start_in,
  input wire logic [`ASF_ADDR_W-1:0] host_rd_addr_in,
  input wire logic data_rd_busy_in,
  // conversion engine events
  input wire logic result_req_in,
  input wire asf_pkg::asf_ch_t result_ch_in,
  input wire logic cal_mode_in,
  input wire logic cal_coef_wr_in,
  input wire logic idle_standby_in,
  input wire logic cal_start_in,
  input wire logic conv_start_in,
  // restart pin and error summary
  input wire logic sync_n_in,
  input wire logic err_any_in,
  // status outputs
  output logic data_ready_n_out,
  output logic result_wr_out,
  output asf_pkg::asf_byte_t status_rdata_out,
  output logic main_err_out
);
  import asf_pkg::*;

  localparam asf_byte_t status_reset = `ASF_STATUS_RESET;

  logic sync_meta_reg;
  logic sync_s_reg;
  logic sync_d_reg;
  logic sync_fall;
  logic rd_status;
  logic rd_data;

  asf_seq_e seq_reg, seq_next;
  asf_cnt_t cnt_reg, cnt_next;
  asf_ch_t pend_ch_reg, pend_ch_next;
  logic rdy_n_reg, rdy_n_next;
  logic unread_reg, unread_next;
  logic por_reg, por_next;
  logic err_reg, err_next;
  asf_ch_t ch_reg, ch_next;
  logic wr_reg, wr_next;
  asf_byte_t rdata_reg, rdata_next;
  asf_byte_t status_word;

  // restart pin is asynchronous to the master clock
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync_meta_reg <= 1'b1;
      sync_s_reg <= 1'b1;
      sync_d_reg <= 1'b1;
    end
    else
    begin
      sync_meta_reg <= sync_n_in;
      sync_s_reg <= sync_meta_reg;
      sync_d_reg <= sync_s_reg;
    end
  end

  assign sync_fall = sync_d_reg && !sync_s_reg;
  assign rd_status = host_rd_start_in &&
    (host_rd_addr_in == `ASF_ADDR_STATUS);
  // coefficient addresses never match here, so they cannot touch the flag
  assign rd_data = host_rd_start_in &&
    (host_rd_addr_in == `ASF_ADDR_DATA);

  always_comb
  begin
    status_word = {8{1'b0}};
    status_word[`ASF_BIT_RDY] = rdy_n_reg;
    status_word[`ASF_BIT_ERR] = err_reg;
    status_word[`ASF_BIT_RSVD] = 1'b0;
    status_word[`ASF_BIT_POR] = por_reg;
    status_word[`ASF_CH_MSB:`ASF_CH_LSB] = ch_reg;
  end

  always_comb
  begin
    seq_next = seq_reg;
    cnt_next = cnt_reg;
    pend_ch_next = pend_ch_reg;
    rdy_n_next = rdy_n_reg;
    unread_next = unread_reg;
    ch_next = ch_reg;
    wr_next = 1'b0;
    // set-to-1 events first; later writes of 0 override them
    if (idle_standby_in || cal_start_in || conv_start_in)
      rdy_n_next = 1'b1;
    if (sync_fall && unread_reg)
      rdy_n_next = 1'b1;
    if (rd_data)
    begin
      rdy_n_next = 1'b1;
      unread_next = 1'b0;
    end
    unique case (seq_reg)
      ASF_IDLE:
      begin
        if (result_req_in)
        begin
          seq_next = ASF_WARN;
          cnt_next = `ASF_PRE_WRITE_CYCLES;
          pend_ch_next = result_ch_in;
          rdy_n_next = 1'b1;
        end
      end
      ASF_WARN:
      begin
        cnt_next = cnt_reg - `ASF_CNT_ONE;
        if (cnt_reg == `ASF_CNT_ONE)
        begin
          seq_next = ASF_IDLE;
          // a read in flight keeps its word; this result is lost
          if (!data_rd_busy_in && !rd_data)
          begin
            wr_next = 1'b1;
            rdy_n_next = 1'b0;
            unread_next = 1'b1;
            ch_next = pend_ch_reg;
          end
        end
      end
    endcase
    // coefficient write wins over the warning raise of the same cycle
    if (cal_mode_in && cal_coef_wr_in)
      rdy_n_next = 1'b0;
  end

  always_comb
  begin
    err_next = err_any_in;
    por_next = por_reg && !rd_status;
    rdata_next = rd_status ? status_word : rdata_reg;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      seq_reg <= ASF_IDLE;
      cnt_reg <= `ASF_CNT_ZERO;
      pend_ch_reg <= `ASF_CH_RESET;
      rdy_n_reg <= status_reset[`ASF_BIT_RDY];
      unread_reg <= 1'b0;
      ch_reg <= `ASF_CH_RESET;
      wr_reg <= 1'b0;
      err_reg <= 1'b0;
      por_reg <= status_reset[`ASF_BIT_POR];
      rdata_reg <= `ASF_STATUS_RESET;
    end
    else
    begin
      seq_reg <= seq_next;
      cnt_reg <= cnt_next;
      pend_ch_reg <= pend_ch_next;
      rdy_n_reg <= rdy_n_next;
      unread_reg <= unread_next;
      ch_reg <= ch_next;
      wr_reg <= wr_next;
      err_reg <= err_next;
      por_reg <= por_next;
      rdata_reg <= rdata_next;
    end
  end

  assign data_ready_n_out = rdy_n_reg;
  assign result_wr_out = wr_reg;
  assign status_rdata_out = rdata_reg;
  assign main_err_out = err_reg;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  result_zero_a: assert property (result_wr_out |-> !data_ready_n_out)
    else $error("ready flag not 0 after result write");
  coef_zero_a: assert property ((cal_mode_in && cal_coef_wr_in) |=>
    !data_ready_n_out)
    else $error("ready flag not 0 after coefficient write");
  data_read_a: assert property ((rd_data && !(cal_mode_in && cal_coef_wr_in)
    && seq_reg == ASF_IDLE) |=> data_ready_n_out)
    else $error("data read did not set ready flag");
  start_set_a: assert property ((conv_start_in && !cal_coef_wr_in &&
    !result_wr_out && seq_reg == ASF_IDLE) |=> data_ready_n_out)
    else $error("conversion start did not set ready flag");
  warn_four_a: assert property ((seq_reg == ASF_IDLE && result_req_in &&
    !data_rd_busy_in && !host_rd_start_in)[*1] ##1 (!data_rd_busy_in &&
    !host_rd_start_in && !cal_coef_wr_in)[*4] |=> result_wr_out)
    else $error("result write not four cycles after warning");
  warn_high_a: assert property ((seq_reg == ASF_IDLE && result_req_in &&
    !cal_coef_wr_in) |=> data_ready_n_out ##1 !result_wr_out
    ##1 !result_wr_out ##1 !result_wr_out)
    else $error("flag not raised ahead of result write");
  abort_a: assert property ((seq_reg == ASF_WARN && cnt_reg == `ASF_CNT_ONE
    && data_rd_busy_in) |=> !result_wr_out && $stable(ch_reg))
    else $error("result written during data read");
  err_follow_a: assert property (err_any_in |=> main_err_out ##0
    status_word[`ASF_BIT_ERR])
    else $error("main error does not follow error summary");
  por_clear_a: assert property (rd_status |=> !por_reg ##1
    !por_reg)
    else $error("power-on flag not cleared by status read");
  chan_follow_a: assert property (result_wr_out |-> ch_reg ==
    $past(pend_ch_reg))
    else $error("channel field does not follow stored result");
  rsvd_zero_a: assert property (!status_rdata_out[`ASF_BIT_RSVD])
    else $error("reserved status bit not zero");

  result_cov_c: cover property (result_req_in ##5 result_wr_out);
  abort_cov_c: cover property (seq_reg == ASF_WARN && data_rd_busy_in
    && cnt_reg == `ASF_CNT_ONE);
  sync_cov_c: cover property (sync_fall && unread_reg);
  por_cov_c: cover property (rd_status && por_reg);

endmodule // asf_adc_status_flags

`default_nettype wire

// [asf_regs.svh]
`ifndef ASF_REGS_SVH
`define ASF_REGS_SVH

// register addresses on the serial interface
`define ASF_ADDR_STATUS 6'h00
`define ASF_ADDR_DATA 6'h02
`define ASF_ADDR_W 6

// condition flags register layout and reset value
`define ASF_STATUS_RESET 8'h10
`define ASF_BIT_RDY 7
`define ASF_BIT_ERR 6
`define ASF_BIT_RSVD 5
`define ASF_BIT_POR 4
`define ASF_CH_MSB 3
`define ASF_CH_LSB 0
`define ASF_CH_RESET 4'h0

// master-clock cycles between flag raise and result write
`define ASF_PRE_WRITE_CYCLES 3'h4
`define ASF_CNT_ONE 3'h1
`define ASF_CNT_ZERO 3'h0

`endif

// [asf_pkg.sv]
package asf_pkg;
  typedef enum logic [0:0] {ASF_IDLE, ASF_WARN} asf_seq_e;
  typedef logic [3:0] asf_ch_t;
  typedef logic [2:0] asf_cnt_t;
  typedef logic [7:0] asf_byte_t;
endpackage

// [asf_host_model.sv]
`timescale 1ns/10ps
`default_nettype none

module asf_host_model
(
  // clock
  input wire logic clk_in,
  // decoded host reads
  output logic rd_start_out,
  output logic [5:0] rd_addr_out,
  output logic rd_busy_out
);
  logic [7:0] cmd;
  initial
  begin
    rd_start_out = 1'b0;
    rd_addr_out = 6'h3F;
    rd_busy_out = 1'b0;
  end
  task automatic rd(input logic [5:0] addr);
    cmd = {1'b0, 1'b1, addr};
    @(negedge clk_in);
    rd_start_out = 1'b1;
    rd_addr_out = cmd[5:0];
    @(negedge clk_in);
    rd_start_out = 1'b0;
    // released address shows its inverse, never a stale copy
    rd_addr_out = ~cmd[5:0];
  endtask
  task automatic busy(input logic b);
    rd_busy_out = b;
  endtask
endmodule // asf_host_model

`default_nettype wire

// [tb_adc_status_flags.sv]
`include "asf_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module tb_adc_status_flags;
  import asf_pkg::*;
  logic clk, rst_n, rd_start, rd_busy, req, cal_mode, coef_wr;
  logic idle_sb, cal_st, conv_st, sync_n, err_any, ready_n, wr, m_err;
  logic [5:0] rd_addr;
  asf_ch_t ch;
  asf_byte_t rdata;
  int bad_count = 0;
  int cmp_count = 0;
  asf_host_model i_host (.clk_in(clk), .rd_start_out(rd_start),
    .rd_addr_out(rd_addr), .rd_busy_out(rd_busy));
  asf_adc_status_flags i_dut (.core_clk_in(clk), .rst_n_in(rst_n),
    .host_rd_start_in(rd_start), .host_rd_addr_in(rd_addr),
    .data_rd_busy_in(rd_busy), .result_req_in(req), .result_ch_in(ch),
    .cal_mode_in(cal_mode), .cal_coef_wr_in(coef_wr),
    .idle_standby_in(idle_sb), .cal_start_in(cal_st),
    .conv_start_in(conv_st), .sync_n_in(sync_n), .err_any_in(err_any),
    .data_ready_n_out(ready_n), .result_wr_out(wr),
    .status_rdata_out(rdata), .main_err_out(m_err));
  task automatic chk(input string what, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic t_result(input asf_ch_t c, input logic [7:0] st);
    @(negedge clk);
    req = 1'b1;
    ch = c;
    @(negedge clk);
    req = 1'b0;
    ch = ~c;
    chk("warn flag", 8'(ready_n), 8'h01);
    for (int i = 1; i <= 4; i++)
    begin
      @(negedge clk);
      // write lands only when the read path is idle
      chk("write", 8'(wr), 8'((i == 4) && (st[7] == 1'b0)));
    end
    chk("ready", 8'(ready_n), 8'(st[7]));
    i_host.rd(`ASF_ADDR_STATUS);
    chk("status", rdata, st);
  endtask
  task automatic coef();
    @(negedge clk);
    cal_mode = 1'b1;
    coef_wr = 1'b1;
    @(negedge clk);
    coef_wr = 1'b0;
    cal_mode = 1'b0;
    chk("cal write", 8'(ready_n), 8'h00);
  endtask
  task automatic t_flags();
    @(negedge clk);
    sync_n = 1'b0;
    for (int i = 0; i < 8 && ready_n !== 1'b1; i++)
      @(negedge clk);
    chk("restart", 8'(ready_n), 8'h01);
    sync_n = 1'b1;
    coef();
    i_host.rd(6'h03);
    chk("coef read", 8'(ready_n), 8'h00);
    i_host.rd(`ASF_ADDR_DATA);
    chk("data read", 8'(ready_n), 8'h01);
    coef();
    sync_n = 1'b0;
    repeat (4) @(negedge clk);
    chk("restart after read", 8'(ready_n), 8'h00);
    sync_n = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      coef();
      {idle_sb, cal_st, conv_st} = 3'h4 >> k;
      @(negedge clk);
      {idle_sb, cal_st, conv_st} = 3'h0;
      chk("set event", 8'(ready_n), 8'h01);
    end
  endtask
  task automatic t_err();
    err_any = 1'b1;
    @(negedge clk);
    chk("main err", 8'(m_err), 8'h01);
    i_host.rd(`ASF_ADDR_STATUS);
    chk("status err", rdata, 8'hC5);
    err_any = 1'b0;
    @(negedge clk);
    chk("main err", 8'(m_err), 8'h00);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    {rst_n, req, cal_mode, coef_wr, idle_sb, cal_st, conv_st} = 7'h00;
    {sync_n, err_any, ch} = 6'h20;
    repeat (6) @(negedge clk);
    chk("reset pin", 8'(ready_n), 8'h00);
    rst_n = 1'b1;
    i_host.rd(`ASF_ADDR_STATUS);
    chk("status reset", rdata, 8'h10);
    i_host.rd(`ASF_ADDR_STATUS);
    chk("por cleared", rdata, 8'h00);
    t_result(4'h5, 8'h05);
    t_flags();
    i_host.busy(1'b1);
    t_result(4'h9, 8'h85);
    i_host.busy(1'b0);
    t_err();
    results();
  end
  initial
  begin
    #20us;
    bad_count++;
    results();
  end
endmodule // tb_adc_status_flags

`default_nettype wire
